// ### core/lcc_params.svh
`ifndef LCC_PARAMS_SVH
`define LCC_PARAMS_SVH

// cluster geometry
`define LCC_NUM_MODULES      10
`define LCC_NUM_ROW_CLK      6
`define LCC_NUM_CCLK         3
`define LCC_RAM_DEPTH        64
`define LCC_SYNC_W           13

// register byte offsets
`define LCC_ADR_CTRL         8'h00
`define LCC_ADR_MOD_CLK      8'h04
`define LCC_ADR_MOD_CTL      8'h08
`define LCC_ADR_RAM_CFG      8'h0C
`define LCC_ADR_RAM_WR       8'h10
`define LCC_ADR_RAM_RADDR    8'h14
`define LCC_ADR_RAM_RDATA    8'h18
`define LCC_ADR_STATUS       8'h1C

// reset values
`define LCC_RST_CTRL         12'h000
`define LCC_RST_MOD_CLK      20'hF_FFFF
`define LCC_RST_MOD_CTL      20'h0_0000
`define LCC_RST_RAM_SEL      10'h000
`define LCC_RST_RADDR        6'h00

// field positions
`define LCC_CTRL_SRC0_LSB    0
`define LCC_CTRL_SRC1_LSB    3
`define LCC_CTRL_CSRC_LSB    6
`define LCC_CTRL_EDGE_LSB    9
`define LCC_MODCTL_CHAIN_LSB 10
`define LCC_RAMCFG_MODE_BIT  16
`define LCC_RAMWR_ADDR_LSB   20
`define LCC_RAMWR_HI_LSB     10

// module clock select code for an unclocked module
`define LCC_CLK_NONE         2'h3

`endif

// ### core/lcc_pkg.sv
package lcc_pkg;

	// active edge of a cluster clock source
	typedef enum logic {
		LCC_EDGE_RISE = 1'b0,
		LCC_EDGE_FALL = 1'b1
	} lcc_edge_t;

	// shape of each ram slice
	typedef enum logic {
		LCC_RAM_64X1 = 1'b0,
		LCC_RAM_32X2 = 1'b1
	} lcc_ram_mode_t;

endpackage

// ### core/lcc_clock_gate.sv
`timescale 1ns/10ps
`default_nettype none

module lcc_clock_gate
	import lcc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       src_lvl_i,
	input  wire lcc_edge_t  edge_i,
	input  wire logic       enable_i,
	output logic            gclk_o,
	output logic            tick_o
);

	logic phase;
	logic en_latch_reg;
	logic phase_d_reg;
	logic gclk_reg;
	logic tick_reg;

	// falling-edge use runs on the inverted source
	assign phase = (edge_i == LCC_EDGE_FALL) ? ~src_lvl_i : src_lvl_i;

	// enable only taken while the source is low, so no runt pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_latch_reg <= 1'b0;
		end else if (!phase) begin
			en_latch_reg <= enable_i; // [RQ14]
		end
	end

	// gated level and one-cycle tick at its rising edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_d_reg <= 1'b0;
			gclk_reg    <= 1'b0;
			tick_reg    <= 1'b0;
		end else begin
			phase_d_reg <= phase;
			gclk_reg    <= phase & en_latch_reg; // [RQ9]
			tick_reg    <= phase & ~phase_d_reg & en_latch_reg;
		end
	end

	assign gclk_o = gclk_reg;
	assign tick_o = tick_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_gate_latch_stable: assert property ( // [RQ14]
		phase |=> (en_latch_reg == $past(en_latch_reg)))
		else $error("gate enable changed while source high");

	chk_gate_clock_off: assert property ( // [RQ9]
		(!en_latch_reg && !enable_i) [*2] |=> !gclk_reg)
		else $error("gated clock ran with enable low");

	chk_gate_tick_pulse: assert property ( // [RQ9]
		tick_reg |-> gclk_reg && !$past(gclk_reg))
		else $error("tick not aligned to gated clock rise");

endmodule

`default_nettype wire

// ### core/lcc_cluster_top.sv
// Functional notes
// (RQ1) The cluster holds ten logic modules whose registers can pass along a dedicated chain.
// (RQ2) The chain feeds one module's register straight into the next one's, bypassing routing.
// (RQ3) The memory variant offers up to 640 bits of simple dual-port RAM, one write and one read port.
// (RQ4) Each ram slice is 64x1 or 32x2, giving a 64x10 or 32x20 memory overall.
// (RQ5) Every module can be picked as either a logic module or a ram slice.
// (RQ6) The control block drives at most ten control lines: 3 clocks, 3 enables, 2 aclr, sclr, sload.
// (RQ7) Up to three cluster clocks are made from two clock sources and three enables.
// (RQ8) Each cluster clock is tied to its own enable, number for number.
// (RQ9) A deasserted enable stops its cluster clock altogether.
// (RQ10) Using both edges of one source takes two of the cluster clocks.
// (RQ11) Control lines come from the six row clocks [5:0] and the local interconnect.
// (RQ12) A cluster drives its own ten modules and ten in each neighbour through direct links.
// (RQ13) Clock, clears, load and enable act on every module register in every mode.
// (RQ14) Enable gating is glitch-free, changing the gated clock only while the source is low.
//
// The Wishbone slave port and the register offsets were left to the implementer.
`include "lcc_params.svh"
`timescale 1ns/10ps
`default_nettype none

module lcc_cluster_top
	import lcc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [5:0]  row_clk_i,
	input  wire logic [2:0]  local_en_i,
	input  wire logic [1:0]  local_aclr_i,
	input  wire logic        local_sclr_i,
	input  wire logic        local_sload_i,
	input  wire logic [9:0]  mod_data_i,
	input  wire logic [9:0]  load_data_i,
	input  wire logic        chain_in_i,
	output logic      [9:0]  mod_q_o,
	output logic      [9:0]  link_left_o,
	output logic      [9:0]  link_right_o,
	output logic             chain_out_o,
	output logic      [9:0]  cluster_ctrl_o,
	output logic      [2:0]  cluster_clk_o
);

	localparam int NM = `LCC_NUM_MODULES;
	localparam int NC = `LCC_NUM_CCLK;
	localparam int AW = $clog2(`LCC_RAM_DEPTH);

	// byte-lane merge for partial writes
	function automatic logic [31:0] merge_bytes(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel
	);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res;
	endfunction

	// row clock pick; codes beyond the six lines give a quiet source
	function automatic logic pick_line(
		input logic [5:0] lines,
		input logic [2:0] sel
	);
		return (sel < 3'h6) ? lines[sel] : 1'b0;
	endfunction

	// module clock pick; the spare code leaves the module unclocked
	function automatic logic pick_tick(
		input logic [2:0] ticks,
		input logic [1:0] sel
	);
		return (sel == `LCC_CLK_NONE) ? 1'b0 : ticks[sel];
	endfunction

	logic [`LCC_SYNC_W-1:0] sync1_reg;
	logic [`LCC_SYNC_W-1:0] sync2_reg;
	logic [5:0]             row_s;
	logic [2:0]             en_s;
	logic [1:0]             aclr_s;
	logic                   sclr_s;
	logic                   sload_s;

	logic [11:0]            ctrl_reg;
	logic [19:0]            mod_clk_reg;
	logic [19:0]            mod_ctl_reg;
	logic [9:0]             ram_sel_reg;
	lcc_ram_mode_t          ram_mode_reg;
	logic [AW-1:0]          raddr_reg;
	logic                   ack_reg;
	logic [31:0]            dat_reg;

	logic                   wb_req;
	logic                   wb_wr;
	logic                   hit_ctrl;
	logic                   hit_mod_clk;
	logic                   hit_mod_ctl;
	logic                   hit_ram_cfg;
	logic                   hit_ram_wr;
	logic                   hit_raddr;
	logic                   hit_rdata;
	logic                   hit_status;
	logic [31:0]            ctrl_wr;
	logic [31:0]            mod_clk_wr;
	logic [31:0]            mod_ctl_wr;
	logic [31:0]            ram_cfg_wr;
	logic [31:0]            raddr_wr;
	logic [31:0]            rd_mux;
	logic [31:0]            status_word;

	logic [1:0]             src_lvl;
	logic [NC-1:0]          cclk_src;
	logic [NC-1:0]          gclk;
	logic [NC-1:0]          tick;
	logic                   both_edges;

	logic [9:0]             mem_reg [0:`LCC_RAM_DEPTH-1];
	logic                   ram_we;
	logic [AW-1:0]          wr_addr;
	logic [19:0]            wr_data;
	logic [AW-1:0]          wr_row_lo;
	logic [AW-1:0]          wr_row_hi;
	logic [AW-1:0]          rd_row_lo;
	logic [AW-1:0]          rd_row_hi;
	logic [19:0]            rd_word;

	logic [9:0]             q_reg;
	logic [9:0]             q_next;
	logic [9:0]             mtick;
	logic [9:0]             maclr;
	logic [9:0]             d_sel;
	logic [9:0]             chain_vec;

	// two-stage synchroniser for row clocks and local control lines
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {local_sload_i, local_sclr_i, local_aclr_i, local_en_i, row_clk_i};
			sync2_reg <= sync1_reg;
		end
	end

	// control lines from row clocks and local interconnect
	assign row_s   = sync2_reg[5:0]; // [RQ11]
	assign en_s    = sync2_reg[8:6];
	assign aclr_s  = sync2_reg[10:9];
	assign sclr_s  = sync2_reg[11];
	assign sload_s = sync2_reg[12];

	// bus request and address decode
	assign wb_req      = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wb_wr       = wb_req & wb_we_i;
	assign hit_ctrl    = (wb_adr_i == `LCC_ADR_CTRL);
	assign hit_mod_clk = (wb_adr_i == `LCC_ADR_MOD_CLK);
	assign hit_mod_ctl = (wb_adr_i == `LCC_ADR_MOD_CTL);
	assign hit_ram_cfg = (wb_adr_i == `LCC_ADR_RAM_CFG);
	assign hit_ram_wr  = (wb_adr_i == `LCC_ADR_RAM_WR);
	assign hit_raddr   = (wb_adr_i == `LCC_ADR_RAM_RADDR);
	assign hit_rdata   = (wb_adr_i == `LCC_ADR_RAM_RDATA);
	assign hit_status  = (wb_adr_i == `LCC_ADR_STATUS);

	// merged write values per register
	assign ctrl_wr    = merge_bytes({20'h0_0000, ctrl_reg}, wb_dat_i, wb_sel_i);
	assign mod_clk_wr = merge_bytes({12'h000, mod_clk_reg}, wb_dat_i, wb_sel_i);
	assign mod_ctl_wr = merge_bytes({12'h000, mod_ctl_reg}, wb_dat_i, wb_sel_i);
	assign ram_cfg_wr = merge_bytes({15'h0000, ram_mode_reg, 6'h00, ram_sel_reg}, wb_dat_i,
		wb_sel_i);
	assign raddr_wr   = merge_bytes({26'h000_0000, raddr_reg}, wb_dat_i, wb_sel_i);

	// configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg    <= `LCC_RST_CTRL;
			mod_clk_reg <= `LCC_RST_MOD_CLK;
			mod_ctl_reg <= `LCC_RST_MOD_CTL;
		end else begin
			if (wb_wr && hit_ctrl) begin
				ctrl_reg <= ctrl_wr[11:0];
			end
			if (wb_wr && hit_mod_clk) begin
				mod_clk_reg <= mod_clk_wr[19:0];
			end
			if (wb_wr && hit_mod_ctl) begin
				mod_ctl_reg <= mod_ctl_wr[19:0];
			end
		end
	end

	// ram slice selection and read address
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ram_sel_reg  <= `LCC_RST_RAM_SEL;
			ram_mode_reg <= LCC_RAM_64X1;
			raddr_reg    <= `LCC_RST_RADDR;
		end else begin
			if (wb_wr && hit_ram_cfg) begin
				ram_sel_reg  <= ram_cfg_wr[9:0]; // [RQ5]
				ram_mode_reg <= lcc_ram_mode_t'(ram_cfg_wr[`LCC_RAMCFG_MODE_BIT]);
			end
			if (wb_wr && hit_raddr) begin
				raddr_reg <= raddr_wr[AW-1:0];
			end
		end
	end

	// status: module outputs, enables, gated clocks, both-edge use
	assign status_word = {15'h0000, both_edges, gclk, en_s, q_reg};

	// read data selection; unmapped and write-only offsets read zero
	assign rd_mux = hit_ctrl    ? {20'h0_0000, ctrl_reg} :
	                hit_mod_clk ? {12'h000, mod_clk_reg} :
	                hit_mod_ctl ? {12'h000, mod_ctl_reg} :
	                hit_ram_cfg ? {15'h0000, ram_mode_reg, 6'h00, ram_sel_reg} :
	                hit_raddr   ? {26'h000_0000, raddr_reg} :
	                hit_rdata   ? {12'h000, rd_word} :
	                hit_status  ? status_word : 32'h0000_0000;

	// one-cycle answer to every access, mapped or not
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= wb_req;
			if (wb_req && !wb_we_i) begin
				dat_reg <= rd_mux;
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	// two cluster clock sources from the row clocks
	assign src_lvl[0] = pick_line(row_s, ctrl_reg[`LCC_CTRL_SRC0_LSB +: 3]); // [RQ11]
	assign src_lvl[1] = pick_line(row_s, ctrl_reg[`LCC_CTRL_SRC1_LSB +: 3]);

	// three gated cluster clocks, each tied to its own enable
	for (genvar k = 0; k < NC; k++) begin : g_gate
		assign cclk_src[k] = ctrl_reg[`LCC_CTRL_CSRC_LSB + k] ? src_lvl[1] : src_lvl[0]; // [RQ7]
		lcc_clock_gate u_gate (
			.clk_i     (clk_i),
			.rst_i     (rst_i),
			.src_lvl_i (cclk_src[k]),
			.edge_i    (lcc_edge_t'(ctrl_reg[`LCC_CTRL_EDGE_LSB + k])),
			.enable_i  (en_s[k]), // [RQ8]
			.gclk_o    (gclk[k]),
			.tick_o    (tick[k])
		);
	end

	// flags two cluster clocks taking both edges of one source
	always_comb begin
		both_edges = 1'b0;
		for (int j = 0; j < NC; j++) begin
			for (int k = j + 1; k < NC; k++) begin
				if (ctrl_reg[`LCC_CTRL_CSRC_LSB + j] == ctrl_reg[`LCC_CTRL_CSRC_LSB + k] &&
				    ctrl_reg[`LCC_CTRL_EDGE_LSB + j] != ctrl_reg[`LCC_CTRL_EDGE_LSB + k]) begin
					both_edges = 1'b1; // [RQ10]
				end
			end
		end
	end

	// ram write port, full-word writes only
	assign ram_we    = wb_wr & hit_ram_wr & (wb_sel_i == 4'hF);
	assign wr_addr   = wb_dat_i[`LCC_RAMWR_ADDR_LSB +: AW];
	assign wr_data   = wb_dat_i[19:0];
	assign wr_row_lo = (ram_mode_reg == LCC_RAM_32X2) ? {wr_addr[AW-2:0], 1'b0} : wr_addr;
	assign wr_row_hi = {wr_addr[AW-2:0], 1'b1};

	// slices store 64x1 bits, or a 32x2 pair in two rows
	always_ff @(posedge clk_i) begin
		if (ram_we) begin
			for (int i = 0; i < NM; i++) begin
				if (ram_sel_reg[i]) begin
					mem_reg[wr_row_lo][i] <= wr_data[i]; // [RQ3]
					if (ram_mode_reg == LCC_RAM_32X2) begin
						mem_reg[wr_row_hi][i] <= wr_data[`LCC_RAMWR_HI_LSB + i]; // [RQ4]
					end
				end
			end
		end
	end

	// independent read port
	assign rd_row_lo = (ram_mode_reg == LCC_RAM_32X2) ? {raddr_reg[AW-2:0], 1'b0} : raddr_reg;
	assign rd_row_hi = {raddr_reg[AW-2:0], 1'b1};
	assign rd_word   = (ram_mode_reg == LCC_RAM_32X2) ?
		{mem_reg[rd_row_hi] & ram_sel_reg, mem_reg[rd_row_lo] & ram_sel_reg} :
		{10'h000, mem_reg[rd_row_lo] & ram_sel_reg}; // [RQ4]

	// register chain input: previous module, or the chain pin for the first
	assign chain_vec = {q_reg[NM-2:0], chain_in_i}; // [RQ2]

	// per-module clock, clear and data selection
	always_comb begin
		for (int i = 0; i < NM; i++) begin
			mtick[i] = pick_tick(tick, mod_clk_reg[2*i +: 2]);
			maclr[i] = aclr_s[mod_ctl_reg[i]];
			d_sel[i] = ram_sel_reg[i] ? rd_word[i] :
			           mod_ctl_reg[`LCC_MODCTL_CHAIN_LSB + i] ? chain_vec[i] : mod_data_i[i]; // [RQ5]
		end
	end

	// clear beats clock; sync clear beats sync load, in every mode
	always_comb begin
		for (int i = 0; i < NM; i++) begin
			if (maclr[i]) begin
				q_next[i] = 1'b0; // [RQ13]
			end else if (mtick[i]) begin
				q_next[i] = sclr_s ? 1'b0 : sload_s ? load_data_i[i] : d_sel[i];
			end else begin
				q_next[i] = q_reg[i];
			end
		end
	end

	// ten module registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_reg <= 10'h000;
		end else begin
			q_reg <= q_next; // [RQ1]
		end
	end

	// outputs to own and neighbouring clusters
	assign mod_q_o        = q_reg;
	assign link_left_o    = q_reg; // [RQ12]
	assign link_right_o   = q_reg; // [RQ12]
	assign chain_out_o    = q_reg[NM-1];
	assign cluster_clk_o  = gclk;
	assign cluster_ctrl_o = {gclk, en_s, aclr_s, sclr_s, sload_s}; // [RQ6]

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_ram_wr_lo;
		ram_we && ram_sel_reg[0] && (ram_mode_reg == LCC_RAM_64X1);
	endsequence

	sequence s_ram_wr_pair;
		ram_we && ram_sel_reg[1] && (ram_mode_reg == LCC_RAM_32X2);
	endsequence

	chk_bus_ack_pulse: assert property (
		ack_reg |=> !ack_reg)
		else $error("ack held longer than one cycle");

	chk_bus_ack_follow: assert property (
		(wb_cyc_i && wb_stb_i && !ack_reg) |=> ack_reg)
		else $error("request not answered next cycle");

	chk_aclr_clears_q: assert property ( // [RQ13]
		(maclr != 10'h000) |=> ((q_reg & $past(maclr)) == 10'h000))
		else $error("asynchronous clear left a module set");

	chk_no_tick_hold: assert property ( // [RQ9]
		(mtick == 10'h000 && maclr == 10'h000) |=> (q_reg == $past(q_reg)))
		else $error("module changed without a clock tick");

	chk_ram_write_lo: assert property ( // [RQ3]
		s_ram_wr_lo |=> (mem_reg[$past(wr_row_lo)][0] == $past(wr_data[0])))
		else $error("64x1 write did not land");

	chk_ram_write_hi: assert property ( // [RQ4]
		s_ram_wr_pair |=> (mem_reg[$past(wr_row_hi)][1] == $past(wr_data[11])))
		else $error("32x2 upper bit did not land");

	for (genvar i = 1; i < NM; i++) begin : g_chk_chain
		chk_chain_shift: assert property ( // [RQ2]
			(mtick[i] && !maclr[i] && !sclr_s && !sload_s && !ram_sel_reg[i] &&
			 mod_ctl_reg[`LCC_MODCTL_CHAIN_LSB + i]) |=> (q_reg[i] == $past(q_reg[i-1])))
			else $error("chain did not pass previous module value");
	end

endmodule

`default_nettype wire

// ### tb/lcc_row_clk_model.sv
`timescale 1ns/10ps
`default_nettype none

// row clock network: six free-running lines, each at its own slow rate
module lcc_row_clk_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	output logic      [5:0] row_clk_o
);
	logic [3:0] cnt_reg [6];

	// line k toggles every 4+k cycles, well below a quarter of clk_i
	always_ff @(posedge clk_i) begin
		for (int k = 0; k < 6; k++) begin
			if (rst_i || cnt_reg[k] == 4'(3 + k)) begin
				cnt_reg[k] <= 4'h0;
				row_clk_o[k] <= rst_i ? 1'b0 : ~row_clk_o[k];
			end else begin
				cnt_reg[k] <= cnt_reg[k] + 4'h1;
			end
		end
	end
endmodule

`default_nettype wire

// ### tb/tb_lcc_cluster_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "lcc_params.svh"

module tb_lcc_cluster_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [3:0]  wb_sel_i = 4'h0;
	logic        wb_we_i = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [5:0]  row_clk_i;
	logic [2:0]  local_en_i = 3'h0;
	logic [1:0]  local_aclr_i = 2'h0;
	logic        local_sclr_i = 1'b0;
	logic        local_sload_i = 1'b0;
	logic [9:0]  mod_data_i = 10'h000;
	logic [9:0]  load_data_i = 10'h000;
	logic        chain_in_i = 1'b0;
	logic [9:0]  mod_q_o;
	logic [9:0]  link_left_o;
	logic [9:0]  link_right_o;
	logic        chain_out_o;
	logic [9:0]  cluster_ctrl_o;
	logic [2:0]  cluster_clk_o;
	int          err_count = 0;
	int          checks_done = 0;
	int          hi_len = 0;
	int          exp_hp = 4;
	logic        mon_on = 1'b0;

	lcc_cluster_top u_lcc_cluster_top (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
		.wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .row_clk_i, .local_en_i,
		.local_aclr_i, .local_sclr_i, .local_sload_i, .mod_data_i, .load_data_i,
		.chain_in_i, .mod_q_o, .link_left_o, .link_right_o, .chain_out_o,
		.cluster_ctrl_o, .cluster_clk_o);

	lcc_row_clk_model u_lcc_row_clk_model (.clk_i(clk_i), .rst_i(rst_i), .row_clk_o(row_clk_i));

	always #4 clk_i = ~clk_i;

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_of_test();
		if (err_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// one classic cycle: hold until ack is sampled high, then release
	task automatic wb_xfer(input logic [7:0] a, input logic [31:0] d, input logic we,
		input logic [3:0] s, output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_we_i  <= we;
		wb_sel_i <= s;
		// no local limit: a stuck bus is ended by the watchdog
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask

	task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		wb_xfer(a, d, 1'b1, 4'hF, v);
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		wb_xfer(a, 32'h0000_0000, 1'b0, 4'hF, v);
		check(nm, v, exp);
	endtask

	task automatic ram_chk(input logic [5:0] a, input logic [31:0] exp);
		wb_wr(`LCC_ADR_RAM_RADDR, 32'(a));
		rd_chk("ram_rdata", `LCC_ADR_RAM_RDATA, exp);
	endtask

	// wait for a cluster clock 0 rise and let the module registers settle
	task automatic tick_wait();
		@(posedge cluster_clk_o[0]);
		repeat (3) @(posedge clk_i);
	endtask

	task automatic seen_clk(output logic [2:0] seen);
		seen = 3'h0;
		repeat (40) begin
			@(posedge clk_i);
			seen = seen | cluster_clk_o;
		end
	endtask

	// high pulses of cluster clock 0 must last the selected row half period
	always @(posedge clk_i) begin
		if (cluster_clk_o[0] === 1'b1) begin
			hi_len++;
		end else begin
			if (mon_on && hi_len != 0) check("pulse_width", hi_len, exp_hp);
			hi_len = 0;
		end
	end

	task automatic t_reset();
		check("q_rst", 32'(mod_q_o), 32'h0000_0000);
		check("ctrl_rst", 32'(cluster_ctrl_o), 32'h0000_0000);
		check("cclk_rst", 32'(cluster_clk_o), 32'h0000_0000);
		rd_chk("ctrl_reg", `LCC_ADR_CTRL, 32'h0000_0000);
		rd_chk("mod_clk", `LCC_ADR_MOD_CLK, 32'h000F_FFFF);
		rd_chk("unmapped", 8'h20, 32'h0000_0000);
		wb_wr(`LCC_ADR_MOD_CLK, 32'h0000_0000);
		rd_chk("mod_clk_wr", `LCC_ADR_MOD_CLK, 32'h0000_0000);
		wb_wr(`LCC_ADR_MOD_CTL, 32'h000F_FC00);
		local_en_i <= 3'b001;
		mon_on = 1'b1;
	endtask

	task automatic t_chain();
		tick_wait();
		chain_in_i <= 1'b1;
		for (int n = 1; n <= 10; n++) begin
			tick_wait();
			check("chain_q", 32'(mod_q_o), 32'((1 << n) - 1));
		end
		check("chain_out", 32'(chain_out_o), 32'h0000_0001);
		check("link_l", 32'(link_left_o), 32'h0000_03FF);
		check("link_r", 32'(link_right_o), 32'h0000_03FF);
		chain_in_i <= 1'b0;
	endtask

	task automatic t_gate();
		logic [2:0] seen;
		logic [9:0] q0;
		local_en_i <= 3'b010;
		repeat (20) @(posedge clk_i);
		q0 = mod_q_o;
		seen_clk(seen);
		check("gated_010", 32'(seen), 32'h0000_0002);
		check("q_hold", 32'(mod_q_o), 32'(q0));
		local_en_i <= 3'b101;
		repeat (20) @(posedge clk_i);
		seen_clk(seen);
		check("gated_101", 32'(seen), 32'h0000_0005);
		// enable flips at odd moments while the pulse monitor watches
		for (int i = 0; i < 12; i++) begin
			local_en_i[0] <= ~local_en_i[0];
			repeat (3 + i) @(posedge clk_i);
		end
		local_en_i <= 3'b001;
		repeat (20) @(posedge clk_i);
	endtask

	task automatic t_ctrl();
		wb_wr(`LCC_ADR_MOD_CTL, 32'h0000_03FF);
		load_data_i <= 10'h2A5;
		local_sload_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		tick_wait();
		check("sload_q", 32'(mod_q_o), 32'h0000_02A5);
		local_sclr_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		check("ctrl_lines", 32'(cluster_ctrl_o[6:0]), 32'h0000_0013);
		tick_wait();
		check("sclr_q", 32'(mod_q_o), 32'h0000_0000);
		local_sclr_i <= 1'b0;
		local_sload_i <= 1'b0;
		mod_data_i <= 10'h15A;
		repeat (4) @(posedge clk_i);
		tick_wait();
		check("data_q", 32'(mod_q_o), 32'h0000_015A);
		local_en_i <= 3'b000;
		repeat (20) @(posedge clk_i);
		// modules watch clear line 1, so line 0 must leave them alone
		local_aclr_i <= 2'b01;
		repeat (4) @(posedge clk_i);
		check("aclr_unsel", 32'(mod_q_o), 32'h0000_015A);
		local_aclr_i <= 2'b10;
		repeat (4) @(posedge clk_i);
		check("aclr_q", 32'(mod_q_o), 32'h0000_0000);
		local_aclr_i <= 2'b00;
		local_en_i <= 3'b001;
		repeat (20) @(posedge clk_i);
	endtask

	task automatic t_edge();
		logic [31:0] v;
		wb_wr(`LCC_ADR_CTRL, 32'h0000_0400);
		wb_xfer(`LCC_ADR_STATUS, 32'h0000_0000, 1'b0, 4'hF, v);
		check("both_edge", 32'(v[16]), 32'h0000_0001);
		wb_wr(`LCC_ADR_CTRL, 32'h0000_0000);
		wb_xfer(`LCC_ADR_STATUS, 32'h0000_0000, 1'b0, 4'hF, v);
		check("one_edge", 32'(v[16]), 32'h0000_0000);
	endtask

	// every row line, reached through source 0 and through source 1
	task automatic t_rows();
		for (int r = 0; r < 6; r++) begin
			for (int j = 0; j < 2; j++) begin
				mon_on = 1'b0;
				wb_wr(`LCC_ADR_CTRL, j ? 32'(32'h40 | (r << 3) | (5 - r)) : 32'(r));
				exp_hp = 4 + r;
				repeat (30) @(posedge clk_i);
				mon_on = 1'b1;
				repeat (60) @(posedge clk_i);
			end
		end
		mon_on = 1'b0;
		wb_wr(`LCC_ADR_CTRL, 32'h0000_0000);
		exp_hp = 4;
		repeat (30) @(posedge clk_i);
		mon_on = 1'b1;
	endtask

	task automatic t_ram();
		logic [31:0] v;
		wb_wr(`LCC_ADR_RAM_CFG, 32'h0000_03FF);
		wb_wr(`LCC_ADR_RAM_WR, 32'h00A0_00DE);
		wb_wr(`LCC_ADR_RAM_WR, 32'h00B0_02AF);
		wb_wr(`LCC_ADR_RAM_WR, 32'h03F0_03FF);
		wb_wr(`LCC_ADR_RAM_CFG, 32'h0001_03FF);
		ram_chk(6'd5, 32'h000A_BCDE);
		wb_wr(`LCC_ADR_RAM_WR, 32'h0071_2345);
		wb_wr(`LCC_ADR_RAM_CFG, 32'h0000_03FF);
		ram_chk(6'd14, 32'h0000_0345);
		ram_chk(6'd15, 32'h0000_0048);
		ram_chk(6'd63, 32'h0000_03FF);
		wb_xfer(`LCC_ADR_RAM_WR, 32'h03F0_0000, 1'b1, 4'h7, v);
		ram_chk(6'd63, 32'h0000_03FF);
		wb_wr(`LCC_ADR_RAM_CFG, 32'h0000_000F);
		ram_chk(6'd63, 32'h0000_000F);
		// ram slices capture read bits, logic modules keep their data input
		tick_wait();
		check("ram_q", 32'(mod_q_o), 32'h0000_015F);
	endtask

	// bounded run: a hang counts as a mismatch
	initial begin
		repeat (30000) @(posedge clk_i);
		err_count++;
		end_of_test();
	end

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_chain();
		t_gate();
		t_ctrl();
		t_edge();
		t_rows();
		t_ram();
		end_of_test();
	end
endmodule

`default_nettype wire
